//--- logic/rsc_pkg.sv
package rsc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0] RSC_ADDR_PIN_SEL = 4'h0; // pin reset select
	localparam logic [3:0] RSC_ADDR_MODE1 = 4'h1; // mode control one
	localparam logic [3:0] RSC_ADDR_STATUS = 4'h2; // expiry/powerdown flags
	localparam logic [3:0] RSC_ADDR_CAUSE = 4'h3; // reset cause record

	// ------------------------------------------------------------
	// field positions and values
	// ------------------------------------------------------------
	localparam logic [7:0] RSC_PIN_SEL_GPIO = 8'h55; // pin as port
	localparam logic [7:0] RSC_PIN_SEL_CLEAR = 8'hAA; // pin as clear
	localparam logic [7:0] RSC_PIN_SEL_RO_MASK = 8'h0C; // bits 3 and 2
	localparam int RSC_M1_SYSKEEP = 7; // idle clock keep
	localparam int RSC_M1_SPARE = 3; // spare bit three
	localparam int RSC_M1_DIP = 2; // supply dip flag
	localparam int RSC_M1_WSR = 0; // watchdog ctrl sw reset flag
	localparam int RSC_ST_EXPIRY = 1; // watchdog expiry flag
	localparam int RSC_ST_PDOWN = 0; // powerdown flag

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int RSC_DIP_MIN_US = 120; // minimum low-voltage duration
	localparam int RSC_CLK_MHZ = 125; // system clock rate
	localparam int RSC_DIP_MIN_CYC = RSC_DIP_MIN_US * RSC_CLK_MHZ;
	localparam int RSC_RST_HOLD_CYC = 4; // internal reset pulse length
	localparam int RSC_SLOW_EDGES_MIN = 2; // slow osc edges before reset

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		RSC_MODE_NORMAL = 2'b00,
		RSC_MODE_SLOW = 2'b01,
		RSC_MODE_IDLE = 2'b10,
		RSC_MODE_SLEEP = 2'b11
	} rsc_mode_t;

	typedef struct packed
	{
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rsc_bus_t;

	typedef struct packed
	{
		logic clear_ints; // disable all interrupts
		logic clear_wdt; // clear watchdog and time bases
		logic timers_off; // stop timer modules
		logic ports_input; // all ports to input
		logic sp_top; // stack pointer to top
		logic pc_zero; // program counter to zero
		logic sp_zero; // stack pointer to zero
	} rsc_init_t;

endpackage

//--- logic/rsc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module rsc_sync
	import rsc_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_reg; // first stage, read only by second

	// two flop synchroniser per bit
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clock or negedge rst_n)
			begin
				if (!rst_n)
				begin
					meta_reg[i] <= 1'b0;
					q[i] <= 1'b0;
				end
				else
				begin
					meta_reg[i] <= d[i];
					q[i] <= meta_reg[i];
				end
			end
		end
	endgenerate

	initial
	begin
		if (WIDTH < 1)
			$error("width must be at least one");
	end

endmodule
`default_nettype wire

//--- logic/rsc_top.sv
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - pattern 55 makes shared pin port
// - pattern AA makes pin active-low clear
// - all resets restore selector except watchdog
// - dip monitor always on when running
// - dip reset sets dip flag
// - dips shorter than minimum are ignored
// - reset on third slow edge, two to three periods
// - dip monitor off in sleep/idle
// - dip flag clearable, never software set
// - mode bits 6-4 and 1 read zero
// - running watchdog expiry acts like dip but keeps selector
// - halted expiry clears only pc, sp
// - halted expiry sets expiry and powerdown
// - dip reset keeps expiry, powerdown flags
// - running expiry keeps powerdown, sets expiry
// - power-on disables all interrupts
// - power-on clears watchdog, watchdog starts
// - power-on turns timers off
// - power-on makes ports inputs
// - power-on sets stack pointer top
// - bad watchdog code sets sw flag
// - low clear pin gives full reset
module rsc_top
	import rsc_pkg::*;
#(
	parameter int DIP_MIN_CYC = RSC_DIP_MIN_CYC
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire rsc_bus_t bus,
	output logic [7:0] rdata,
	input wire logic [1:0] mode,
	input wire logic supply_low,
	input wire logic slow_internal_osc,
	input wire logic shared_port_pin,
	input wire logic wdt_expiry,
	input wire logic wdt_bad_code,
	output logic core_reset_n,
	output logic pin_is_clear,
	output logic port_pin_level,
	output var rsc_init_t init
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [2:0] raw_in; // pin inputs from outside
	logic [2:0] sync_in; // synchronised copies
	logic low_s; // supply low, synchronised
	logic osc_s; // slow oscillator level
	logic pin_s; // shared pin level
	assign raw_in = {supply_low, slow_internal_osc, shared_port_pin};

	rsc_sync #(.WIDTH(3)) u_sync
	(
		.clock(clock),
		.rst_n(rst_n),
		.d(raw_in),
		.q(sync_in)
	);
	assign low_s = sync_in[2];
	assign osc_s = sync_in[1];
	assign pin_s = sync_in[0];

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0] pin_sel_reg; // pin reset selector
	logic [7:0] pin_sel_next;
	logic syskeep_reg; // idle clock keep
	logic spare_reg; // spare bit three
	logic dip_flag_reg; // supply dip reset flag
	logic wsr_flag_reg; // watchdog ctrl sw reset flag
	logic expiry_reg; // watchdog expiry flag
	logic pdown_reg; // powerdown flag
	logic [31:0] dip_cnt_reg; // dip duration counter
	logic dip_armed_reg; // qualified dip awaiting slow edges
	logic [1:0] edge_cnt_reg; // slow osc edges seen
	logic osc_d_reg; // previous slow osc level
	logic [2:0] hold_reg; // internal reset pulse counter
	logic por_done_reg; // power-on initialisation issued
	logic [3:0] cause_reg; // last cause: por, pin, dip, wdt
	logic halt_wake_reg; // halted expiry pulse
	rsc_mode_t mode_e;
	assign mode_e = rsc_mode_t'(mode);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic running; // normal or slow mode
	logic wr_sel, wr_mode1, wr_stat; // write decodes
	logic osc_rise; // slow osc rising edge
	logic dip_qual; // dip long enough
	logic dip_fire; // dip reset request
	logic wdt_run; // running expiry
	logic wdt_halt; // halted expiry
	logic pin_clear; // clear pin asserted
	logic full_req; // any full reset request
	logic warm_req; // full except watchdog

	assign running = (mode_e == RSC_MODE_NORMAL) || (mode_e == RSC_MODE_SLOW);
	assign wr_sel = bus.wr && (bus.addr == RSC_ADDR_PIN_SEL);
	assign wr_mode1 = bus.wr && (bus.addr == RSC_ADDR_MODE1);
	assign wr_stat = bus.wr && (bus.addr == RSC_ADDR_STATUS);
	assign osc_rise = osc_s && !osc_d_reg;
	// monitor only while running, no disable bit
	assign dip_qual = running && low_s && (dip_cnt_reg >= DIP_MIN_CYC);
	// reset on third slow edge: two to three periods after arming
	assign dip_fire = dip_armed_reg && osc_rise
		&& (edge_cnt_reg == 2'(RSC_SLOW_EDGES_MIN));
	assign wdt_run = wdt_expiry && running;
	assign wdt_halt = wdt_expiry && !running;
	// clear pin only honoured in clear configuration
	assign pin_is_clear = ((pin_sel_reg ^ RSC_PIN_SEL_CLEAR)
		& ~RSC_PIN_SEL_RO_MASK) == 8'h00;
	assign pin_clear = pin_is_clear && !pin_s;
	assign port_pin_level = pin_is_clear ? 1'b1 : pin_s;
	assign warm_req = dip_fire || pin_clear || wdt_bad_code;
	assign full_req = warm_req || wdt_run;

	// read-only selector bits keep reset value
	assign pin_sel_next = (bus.wdata & ~RSC_PIN_SEL_RO_MASK) | (RSC_PIN_SEL_GPIO & RSC_PIN_SEL_RO_MASK);

	// ------------------------------------------------------------
	// supply dip qualification
	// ------------------------------------------------------------
	// count while low and running, restart otherwise
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			dip_cnt_reg <= 32'h0;
		else if (!(running && low_s) || dip_fire)
			dip_cnt_reg <= 32'h0;
		else if (dip_cnt_reg < DIP_MIN_CYC)
			dip_cnt_reg <= dip_cnt_reg + 32'h1;
	end

	// arm and count slow osc edges
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dip_armed_reg <= 1'b0;
			edge_cnt_reg <= 2'h0;
			osc_d_reg <= 1'b0;
		end
		else
		begin
			osc_d_reg <= osc_s;
			if (dip_fire || !running)
			begin
				dip_armed_reg <= 1'b0;
				edge_cnt_reg <= 2'h0;
			end
			else if (!dip_armed_reg)
				dip_armed_reg <= dip_qual;
			else if (osc_rise)
				edge_cnt_reg <= edge_cnt_reg + 2'h1;
		end
	end

	// ------------------------------------------------------------
	// merged internal reset
	// ------------------------------------------------------------
	// held low a few cycles, released on the clock
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			hold_reg <= 3'(RSC_RST_HOLD_CYC);
		else if (full_req)
			hold_reg <= 3'(RSC_RST_HOLD_CYC);
		else if (hold_reg != 3'h0)
			hold_reg <= hold_reg - 3'h1;
	end
	assign core_reset_n = (hold_reg == 3'h0);

	// ------------------------------------------------------------
	// pin selector register
	// ------------------------------------------------------------
	// restored by all resets except watchdog expiry
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			pin_sel_reg <= RSC_PIN_SEL_GPIO;
		else if (warm_req)
			pin_sel_reg <= RSC_PIN_SEL_GPIO;
		else if (wr_sel)
			pin_sel_reg <= pin_sel_next;
	end

	// ------------------------------------------------------------
	// mode control one
	// ------------------------------------------------------------
	// flags: hardware set wins over software clear
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syskeep_reg <= 1'b0;
			spare_reg <= 1'b0;
			dip_flag_reg <= 1'b0;
			wsr_flag_reg <= 1'b0;
		end
		else
		begin
			if (pin_clear || wdt_bad_code || wdt_run || dip_fire)
			begin
				syskeep_reg <= 1'b0;
				spare_reg <= 1'b0;
			end
			else if (wr_mode1)
			begin
				syskeep_reg <= bus.wdata[RSC_M1_SYSKEEP];
				spare_reg <= bus.wdata[RSC_M1_SPARE];
			end
			if (dip_fire)
				dip_flag_reg <= 1'b1;
			else if (wr_mode1 && !bus.wdata[RSC_M1_DIP])
				dip_flag_reg <= 1'b0;
			if (wdt_bad_code)
				wsr_flag_reg <= 1'b1;
			else if (wr_mode1 && !bus.wdata[RSC_M1_WSR])
				wsr_flag_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// expiry and powerdown flags
	// ------------------------------------------------------------
	// dip keeps both, running expiry sets expiry only
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			expiry_reg <= 1'b0;
			pdown_reg <= 1'b0;
		end
		else if (wdt_halt)
		begin
			expiry_reg <= 1'b1;
			pdown_reg <= 1'b1;
		end
		else if (wdt_run)
			expiry_reg <= 1'b1;
		else if (pin_clear)
		begin
			expiry_reg <= 1'b0;
			pdown_reg <= 1'b0;
		end
		else if (wr_stat)
		begin
			expiry_reg <= bus.wdata[RSC_ST_EXPIRY];
			pdown_reg <= bus.wdata[RSC_ST_PDOWN];
		end
	end

	// ------------------------------------------------------------
	// core initialisation strobes
	// ------------------------------------------------------------
	// power-on pulse, halted expiry pulse, cause record
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			por_done_reg <= 1'b0;
			halt_wake_reg <= 1'b0;
			cause_reg <= 4'h0;
		end
		else
		begin
			por_done_reg <= 1'b1;
			halt_wake_reg <= wdt_halt;
			if (!por_done_reg)
				cause_reg <= 4'h8;
			else if (wdt_expiry)
				cause_reg <= 4'h1;
			else if (dip_fire)
				cause_reg <= 4'h2;
			else if (pin_clear || wdt_bad_code)
				cause_reg <= 4'h4;
		end
	end

	logic por_pulse; // first cycle after power-on
	assign por_pulse = !por_done_reg;
	assign init.clear_ints = por_pulse || !core_reset_n;
	assign init.clear_wdt = por_pulse || !core_reset_n;
	assign init.timers_off = por_pulse || !core_reset_n;
	assign init.ports_input = por_pulse || !core_reset_n;
	assign init.sp_top = por_pulse || !core_reset_n;
	assign init.pc_zero = por_pulse || !core_reset_n || halt_wake_reg;
	assign init.sp_zero = halt_wake_reg;

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	logic [7:0] mode1_val; // unimplemented bits zero
	logic [7:0] rd_val;
	assign mode1_val = {syskeep_reg, 3'b000, spare_reg, dip_flag_reg, 1'b0, wsr_flag_reg};
	assign rd_val = (bus.addr == RSC_ADDR_PIN_SEL) ? pin_sel_reg :
		(bus.addr == RSC_ADDR_MODE1) ? mode1_val :
		(bus.addr == RSC_ADDR_STATUS) ? {6'h00, expiry_reg, pdown_reg} :
		(bus.addr == RSC_ADDR_CAUSE) ? {4'h0, cause_reg} : 8'h00;

	// data one cycle after strobe
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= 8'h00;
		else if (bus.rd)
			rdata <= rd_val;
		else
			rdata <= 8'h00;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	initial
	begin
		if (DIP_MIN_CYC < 1)
			$error("dip minimum must be at least one cycle");
	end

	sequence s_dip_fire;
		dip_fire;
	endsequence

	a_dip_sets_flag: assert property (@(posedge clock) disable iff (!rst_n)
		s_dip_fire |=> dip_flag_reg)
		else $error("dip flag not set");
	a_dip_resets: assert property (@(posedge clock) disable iff (!rst_n)
		s_dip_fire |=> !core_reset_n)
		else $error("dip gave no reset");
	a_short_dip: assert property (@(posedge clock) disable iff (!rst_n)
		dip_fire |-> $past(dip_armed_reg))
		else $error("dip fired without qualification");
	a_halt_monitor: assert property (@(posedge clock) disable iff (!rst_n)
		!running |-> !dip_qual)
		else $error("monitor active when halted");
	a_dip_keeps_flags: assert property (@(posedge clock) disable iff (!rst_n)
		(dip_fire && !wdt_expiry && !pin_clear && !wr_stat) |=> $stable(pdown_reg) && $stable(expiry_reg))
		else $error("dip changed expiry flags");
	a_halt_expiry: assert property (@(posedge clock) disable iff (!rst_n)
		wdt_halt |=> expiry_reg && pdown_reg ##1 init.sp_zero == 1'b0)
		else $error("halted expiry flags wrong");
	a_wdt_keeps_sel: assert property (@(posedge clock) disable iff (!rst_n)
		(wdt_run && !warm_req && !wr_sel) |=> $stable(pin_sel_reg))
		else $error("watchdog changed selector");
	a_pin_clear: assert property (@(posedge clock) disable iff (!rst_n)
		pin_clear |=> !core_reset_n [*4])
		else $error("clear pin pulse too short");
	a_mode1_zero: assert property (@(posedge clock) disable iff (!rst_n)
		bus.rd && bus.addr == RSC_ADDR_MODE1 |=> (rdata & 8'h72) == 8'h00)
		else $error("unimplemented bits not zero");
	a_sel_ro_bits: assert property (@(posedge clock) disable iff (!rst_n)
		pin_sel_reg[3:2] == 2'b01)
		else $error("read-only selector bits changed");

endmodule
`default_nettype wire

//--- testbench/reset_source_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module reset_source_control_tb;
	import rsc_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clock = 1'b0; // system clock
	logic rst_n = 1'b0; // power-on reset
	rsc_bus_t bus = '0; // register requests
	logic [1:0] mode = 2'b00; // operating mode
	logic wdt_expiry = 1'b0; // watchdog expiry pulse
	logic wdt_bad_code = 1'b0; // bad code pulse
	logic dip_on = 1'b0; // ask for a supply dip
	logic pin_low = 1'b0; // ask for the pin low
	logic supply_low, slow_osc, pin_lvl; // far side levels
	logic [7:0] rdata;
	logic core_reset_n, pin_is_clear, port_pin_level;
	rsc_init_t init;
	int error_cnt = 0; // mismatches
	int checked = 0; // comparisons
	int sp_cnt = 0; // cycles with the stack clear pulse
	logic rd_q = 1'b0; // read issued last cycle
	logic [7:0] exp_q[$]; // expected read data

	always #4 clock = ~clock;

	rsc_top #(.DIP_MIN_CYC(8)) i_dut
	(
		.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.mode(mode), .supply_low(supply_low),
		.slow_internal_osc(slow_osc), .shared_port_pin(pin_lvl),
		.wdt_expiry(wdt_expiry), .wdt_bad_code(wdt_bad_code),
		.core_reset_n(core_reset_n), .pin_is_clear(pin_is_clear),
		.port_pin_level(port_pin_level), .init(init)
	);

	rsc_far_model i_far
	(
		.clock(clock), .dip_on(dip_on), .pin_low(pin_low),
		.supply_low(supply_low), .slow_internal_osc(slow_osc),
		.shared_port_pin(pin_lvl)
	);

	// ------------------------------------------------------------
	// checking
	// ------------------------------------------------------------
	task cmp_val(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task complete_run;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// read data stands in the cycle after the strobe
	always @(posedge clock)
	begin
		rd_q <= bus.rd;
	end
	// oldest note is compared whenever read data appears
	always @(negedge clock)
	begin
		if (rd_q === 1'b1)
			cmp_val(rdata, exp_q.pop_front());
		if (init.sp_zero === 1'b1)
			sp_cnt++;
	end

	// ------------------------------------------------------------
	// bus and event drivers
	// ------------------------------------------------------------
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clock);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
	endtask

	task pulse(input logic expiry);
		@(posedge clock);
		if (expiry)
			wdt_expiry <= 1'b1;
		else
			wdt_bad_code <= 1'b1;
		@(posedge clock);
		wdt_expiry <= 1'b0;
		wdt_bad_code <= 1'b0;
	endtask

	// cycles until the core reset shows, n when it never does
	task wait_low(input int n, output int t);
		t = 0;
		while (t < n && core_reset_n !== 1'b0)
		begin
			@(negedge clock);
			t++;
		end
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial
	begin
		int t;
		int s0;
		void'($urandom(32'h69e8));
		repeat (20) @(posedge clock);
		@(negedge clock);
		cmp_val({1'b0, init}, 8'h7E);
		cmp_val({7'h0, core_reset_n}, 8'h00);
		@(posedge clock);
		rst_n <= 1'b1;
		repeat (8) @(posedge clock);
		@(negedge clock);
		cmp_val({7'h0, core_reset_n}, 8'h01);
		cmp_val({1'b0, init}, 8'h00);
		rd(RSC_ADDR_PIN_SEL, 8'h55);
		rd(RSC_ADDR_MODE1, 8'h00);
		wr(RSC_ADDR_PIN_SEL, RSC_PIN_SEL_CLEAR);
		rd(RSC_ADDR_PIN_SEL, 8'hA6);
		wr(RSC_ADDR_PIN_SEL, RSC_PIN_SEL_CLEAR);
		rd(RSC_ADDR_PIN_SEL, 8'hA6);
		@(negedge clock);
		cmp_val({6'h0, pin_is_clear, port_pin_level}, 8'h03);
		// clear pin pulled low gives a full reset
		wr(RSC_ADDR_STATUS, 8'h03);
		pin_low <= 1'b1;
		wait_low(30, t);
		cmp_val({7'h0, t < 30}, 8'h01);
		pin_low <= 1'b0;
		repeat (20) @(posedge clock);
		rd(RSC_ADDR_PIN_SEL, 8'h55);
		rd(RSC_ADDR_STATUS, 8'h00);
		// pin as port: low level is data, not reset
		pin_low <= 1'b1;
		wait_low(30, t);
		cmp_val({7'h0, t == 30}, 8'h01);
		cmp_val({7'h0, port_pin_level}, 8'h00);
		pin_low <= 1'b0;
		// short dip ignored
		@(posedge clock);
		mode <= 2'($urandom % 2);
		dip_on <= 1'b1;
		repeat (4) @(posedge clock);
		dip_on <= 1'b0;
		wait_low(60, t);
		cmp_val({7'h0, t == 60}, 8'h01);
		// long dip while running
		wr(RSC_ADDR_PIN_SEL, RSC_PIN_SEL_CLEAR);
		wr(RSC_ADDR_STATUS, 8'h03);
		dip_on <= 1'b1;
		wait_low(80, t);
		cmp_val({7'h0, t > 40 && t < 80}, 8'h01);
		dip_on <= 1'b0;
		repeat (20) @(posedge clock);
		rd(RSC_ADDR_PIN_SEL, 8'h55);
		rd(RSC_ADDR_STATUS, 8'h03);
		rd(RSC_ADDR_MODE1, 8'h04);
		wr(RSC_ADDR_MODE1, 8'hFF);
		rd(RSC_ADDR_MODE1, 8'h8C);
		wr(RSC_ADDR_MODE1, 8'h00);
		rd(RSC_ADDR_MODE1, 8'h00);
		// dip while halted
		mode <= 2'b10 | 2'($urandom % 2);
		dip_on <= 1'b1;
		wait_low(60, t);
		cmp_val({7'h0, t == 60}, 8'h01);
		dip_on <= 1'b0;
		repeat (4) @(posedge clock);
		// watchdog expiry while running
		mode <= 2'($urandom % 2);
		wr(RSC_ADDR_PIN_SEL, RSC_PIN_SEL_CLEAR);
		wr(RSC_ADDR_STATUS, 8'h01);
		pulse(1'b1);
		wait_low(20, t);
		cmp_val({7'h0, t < 20}, 8'h01);
		repeat (20) @(posedge clock);
		rd(RSC_ADDR_PIN_SEL, 8'hA6);
		rd(RSC_ADDR_STATUS, 8'h03);
		wr(RSC_ADDR_PIN_SEL, RSC_PIN_SEL_GPIO);
		// watchdog expiry while halted
		wr(RSC_ADDR_STATUS, 8'h00);
		mode <= 2'b10 | 2'($urandom % 2);
		s0 = sp_cnt;
		pulse(1'b1);
		wait_low(20, t);
		cmp_val({7'h0, t == 20}, 8'h01);
		cmp_val(8'(sp_cnt - s0), 8'h01);
		rd(RSC_ADDR_STATUS, 8'h03);
		// bad watchdog code
		mode <= 2'b00;
		pulse(1'b0);
		wait_low(20, t);
		cmp_val({7'h0, t < 20}, 8'h01);
		repeat (20) @(posedge clock);
		rd(RSC_ADDR_MODE1, 8'h01);
		rd(RSC_ADDR_CAUSE, 8'h04);
		// unmapped place
		wr(4'hF, 8'($urandom));
		rd(4'hF, 8'h00);
		rd(RSC_ADDR_PIN_SEL, 8'h55);
		repeat (4) @(posedge clock);
		complete_run;
	end

	// hang guard, run needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clock);
		error_cnt++;
		complete_run;
	end
endmodule
`default_nettype wire

//--- testbench/rsc_far_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// far side: supply monitor, slow oscillator, clear pin circuit
// ------------------------------------------------------------
module rsc_far_model
(
	input wire logic clock,
	input wire logic dip_on,
	input wire logic pin_low,
	output logic supply_low,
	output logic slow_internal_osc,
	output logic shared_port_pin
);
	logic [3:0] div_reg = 4'h0; // slow osc divider

	// slow oscillator runs free, sixteen clocks a period
	always @(posedge clock)
	begin
		div_reg <= div_reg + 4'h1;
	end
	assign slow_internal_osc = div_reg[3];
	// supply held in the dip range on request
	assign supply_low = dip_on;
	// external pull-up keeps the pin high unless driven low
	assign shared_port_pin = !pin_low;
endmodule
`default_nettype wire
